// ### rcf_pkg.sv
/*
 * rcf_pkg: constants for the reset cause flag register block.
 * Assumes a single 40 MHz clock and a plain address/strobe register port.
 */
package rcf_pkg;
    localparam logic [3:0] RCF_ADDR_FLAGS = 4'h0;    // flag register offset
    localparam int RCF_BIT_IO_POR = 31;              // io_supply_por_flag
    localparam int RCF_BIT_CORE_POR = 30;            // core_supply_por_flag
    localparam int RCF_BIT_BK_POR = 17;              // backup_domain_por_flag
    localparam int RCF_BIT_BK_EXIT = 16;             // backup exit flag
    localparam int RCF_BIT_DEEP_SLEEP = 10;          // deep_sleep_flag
    localparam int RCF_BIT_CFG_MISMATCH = 9;         // config_mismatch_flag
    localparam int RCF_BIT_PIN_RESET = 7;            // pin_reset_flag
    localparam int RCF_BIT_SOFT_RESET = 6;           // soft_reset_flag
    localparam logic [31:0] RCF_IMPL_MASK = 32'hc003_06ff; // implemented bits
    localparam logic [31:0] RCF_RESET_VAL = 32'h0003_0003; // value after power-on
endpackage : rcf_pkg

// ### rcf_reset_cause.sv
/*
 * rcf_reset_cause: 32-bit sticky reset cause flag register.
 * Assumes event inputs are one-cycle or level pulses synchronous to clk,
 * and rstn is the power-on reset of the always-on domain only.
 */
`timescale 1ns/10ps
module rcf_reset_cause
    import rcf_pkg::*;
(
    input wire logic clk,              // 40 MHz system clock
    input wire logic rstn,             // async active-low power-on reset
    input wire logic [3:0] addr,       // register address
    input wire logic [31:0] wdata,     // write data
    input wire logic wr,               // write strobe
    input wire logic rd,               // read strobe
    input wire logic [31:0] hw_set,    // hardware event per flag bit
    output logic [31:0] rdata,         // read data, one cycle after rd
    output logic [31:0] flags          // live flag value
);
    logic [31:0] flag_q;               // stored flags
    logic boot_q;                      // high for the first cycle after reset
    wire hit = addr == RCF_ADDR_FLAGS; // address decode
    wire wr_hit = wr & hit;            // write to flag register
    wire rd_hit = rd & hit;            // read of flag register
    wire [31:0] set_m = hw_set & RCF_IMPL_MASK; // only implemented bits set
    wire [31:0] rd_val = hit ? flag_q : 32'h0000_0000; // unmapped reads zero
    wire [31:0] next_flags;            // value stored at the next edge

    // one cell per bit: a write only stores the bit, it never starts a reset,
    // and a hardware set in the same cycle beats a clearing write
    for (genvar gi = 0; gi < 32; gi++) begin : g_cell
        if (RCF_IMPL_MASK[gi]) begin : g_impl
            // implemented: set, else written value, else hold
            assign next_flags[gi] = set_m[gi] | (wr_hit ? wdata[gi] : flag_q[gi]);
        end else begin : g_none
            // unimplemented: tied low, writes have no effect
            assign next_flags[gi] = 1'b0;
        end
    end

    // flag storage, hardware set wins over software clear
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            flag_q <= RCF_RESET_VAL;
        end else begin
            flag_q <= next_flags;
        end
    end

    // read port and mirror outputs
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rdata <= 32'h0000_0000;
            flags <= RCF_RESET_VAL;
        end else begin
            rdata <= rd ? rd_val : 32'h0000_0000;
            flags <= next_flags;
        end
    end

    // first-cycle marker used only by the reset-value check
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            boot_q <= 1'b1;            // set while in reset
        end else begin
            boot_q <= 1'b0;            // cleared at the first edge after release
        end
    end

    // read request to the flag register
    sequence s_rd_req;
        rd_hit;
    endsequence
    // answer one cycle later: the stored value, nothing else
    sequence s_rd_ans;
        rdata == $past(flag_q);
    endsequence
    // write with no hardware event beside it
    sequence s_clr_req;
        wr_hit && (set_m == 32'h0000_0000);
    endsequence
    // stored value equals the written data, masked
    sequence s_clr_done;
        flag_q == ($past(wdata) & RCF_IMPL_MASK);
    endsequence

    // an io supply event shows in the stored flag one edge later
    // whatever else happens in that cycle
    property p_io_set;
        @(posedge clk) disable iff (!rstn)
            hw_set[RCF_BIT_IO_POR] |=> flag_q[RCF_BIT_IO_POR];
    endproperty
    a_io_set: assert property (p_io_set) else $error("io flag not set");

    // a core supply event shows on the mirror output one edge later
    // the mirror is what software-facing logic looks at
    property p_core_set;
        @(posedge clk) disable iff (!rstn)
            hw_set[RCF_BIT_CORE_POR] |=> flags[RCF_BIT_CORE_POR];
    endproperty
    a_core_set: assert property (p_core_set) else $error("core flag not set");

    // without a write no flag ever drops
    // flags are only cleared by software
    property p_sticky;
        @(posedge clk) disable iff (!rstn)
            !wr_hit |=> ((flag_q & $past(flag_q)) == $past(flag_q));
    endproperty
    a_sticky: assert property (p_sticky) else $error("flag lost without write");

    // unimplemented positions never hold a one
    // they are tied low in the cell loop
    property p_unimpl;
        @(posedge clk) disable iff (!rstn)
            (flag_q & ~RCF_IMPL_MASK) == 32'h0000_0000;
    endproperty
    a_unimpl: assert property (p_unimpl) else $error("unimplemented bit set");

    // a write stores the data, with same-cycle events or-ed in
    // so an event is never lost to a clearing write
    property p_write;
        @(posedge clk) disable iff (!rstn)
            wr_hit |=> flag_q == (($past(wdata) | $past(hw_set)) & RCF_IMPL_MASK);
    endproperty
    a_write: assert property (p_write) else $error("write value wrong");

    // a pin reset event survives a same-cycle clearing write
    // hardware set has priority over software
    property p_pin;
        @(posedge clk) disable iff (!rstn)
            hw_set[RCF_BIT_PIN_RESET] && wr_hit |=> flag_q[RCF_BIT_PIN_RESET];
    endproperty
    a_pin: assert property (p_pin) else $error("pin flag cleared by write");

    // read data stands one cycle after the strobe
    // software reads before it clears, so the value must be exact
    property p_read;
        @(posedge clk) disable iff (!rstn)
            s_rd_req |=> s_rd_ans;
    endproperty
    a_read: assert property (p_read) else $error("read data wrong");

    // read data returns to zero when no read was made
    // keeps stale flags off the bus
    property p_idle_rd;
        @(posedge clk) disable iff (!rstn)
            !rd |=> rdata == 32'h0000_0000;
    endproperty
    a_idle_rd: assert property (p_idle_rd) else $error("rdata not idle");

    // a backup domain event sets its flag one edge later
    // checked on the stored value
    property p_bk_por_set;
        @(posedge clk) disable iff (!rstn)
            hw_set[RCF_BIT_BK_POR] |=> flag_q[RCF_BIT_BK_POR];
    endproperty
    a_bk_por_set: assert property (p_bk_por_set) else $error("backup flag not set");

    // a backup exit event sets its flag one edge later
    // checked on the stored value
    property p_bk_exit_set;
        @(posedge clk) disable iff (!rstn)
            hw_set[RCF_BIT_BK_EXIT] |=> flag_q[RCF_BIT_BK_EXIT];
    endproperty
    a_bk_exit_set: assert property (p_bk_exit_set) else $error("exit flag not set");

    // a deep sleep entry sets its flag one edge later
    // checked on the stored value
    property p_deep_set;
        @(posedge clk) disable iff (!rstn)
            hw_set[RCF_BIT_DEEP_SLEEP] |=> flag_q[RCF_BIT_DEEP_SLEEP];
    endproperty
    a_deep_set: assert property (p_deep_set) else $error("sleep flag not set");

    // a configuration mismatch sets its flag one edge later
    // checked on the stored value
    property p_cfg_set;
        @(posedge clk) disable iff (!rstn)
            hw_set[RCF_BIT_CFG_MISMATCH] |=> flag_q[RCF_BIT_CFG_MISMATCH];
    endproperty
    a_cfg_set: assert property (p_cfg_set) else $error("mismatch flag not set");

    // a master clear pin reset sets its flag one edge later
    // with or without a write beside it
    property p_pin_set;
        @(posedge clk) disable iff (!rstn)
            hw_set[RCF_BIT_PIN_RESET] |=> flag_q[RCF_BIT_PIN_RESET];
    endproperty
    a_pin_set: assert property (p_pin_set) else $error("pin flag not set");

    // a software reset sets its flag one edge later
    // checked on the stored value
    property p_soft_set;
        @(posedge clk) disable iff (!rstn)
            hw_set[RCF_BIT_SOFT_RESET] |=> flag_q[RCF_BIT_SOFT_RESET];
    endproperty
    a_soft_set: assert property (p_soft_set) else $error("soft flag not set");

    // the io flag holds until a write to the register
    // so software sees every detection
    property p_io_hold;
        @(posedge clk) disable iff (!rstn)
            flag_q[RCF_BIT_IO_POR] && !wr_hit |=> flag_q[RCF_BIT_IO_POR];
    endproperty
    a_io_hold: assert property (p_io_hold) else $error("io flag dropped");

    // the core flag holds until a write to the register
    // so software sees every detection
    property p_core_hold;
        @(posedge clk) disable iff (!rstn)
            flag_q[RCF_BIT_CORE_POR] && !wr_hit |=> flag_q[RCF_BIT_CORE_POR];
    endproperty
    a_core_hold: assert property (p_core_hold) else $error("core flag dropped");

    // the backup domain flag holds until a write
    // no other path clears it
    property p_bk_por_hold;
        @(posedge clk) disable iff (!rstn)
            flag_q[RCF_BIT_BK_POR] && !wr_hit |=> flag_q[RCF_BIT_BK_POR];
    endproperty
    a_bk_por_hold: assert property (p_bk_por_hold) else $error("backup flag dropped");

    // the backup exit flag holds until a write
    // no other path clears it
    property p_bk_exit_hold;
        @(posedge clk) disable iff (!rstn)
            flag_q[RCF_BIT_BK_EXIT] && !wr_hit |=> flag_q[RCF_BIT_BK_EXIT];
    endproperty
    a_bk_exit_hold: assert property (p_bk_exit_hold) else $error("exit flag dropped");

    // the deep sleep flag holds until software clears it
    // so the next entry can be told apart
    property p_deep_hold;
        @(posedge clk) disable iff (!rstn)
            flag_q[RCF_BIT_DEEP_SLEEP] && !wr_hit |=> flag_q[RCF_BIT_DEEP_SLEEP];
    endproperty
    a_deep_hold: assert property (p_deep_hold) else $error("sleep flag dropped");

    // the mismatch flag holds until a write
    // no other path clears it
    property p_cfg_hold;
        @(posedge clk) disable iff (!rstn)
            flag_q[RCF_BIT_CFG_MISMATCH] && !wr_hit |=> flag_q[RCF_BIT_CFG_MISMATCH];
    endproperty
    a_cfg_hold: assert property (p_cfg_hold) else $error("mismatch flag dropped");

    // the software reset flag holds until a write
    // no other path clears it
    property p_soft_hold;
        @(posedge clk) disable iff (!rstn)
            flag_q[RCF_BIT_SOFT_RESET] && !wr_hit |=> flag_q[RCF_BIT_SOFT_RESET];
    endproperty
    a_soft_hold: assert property (p_soft_hold) else $error("soft flag dropped");

    // writing a one to the io flag stores a one
    // the write touches only the stored bit
    property p_io_wr_one;
        @(posedge clk) disable iff (!rstn)
            wr_hit && wdata[RCF_BIT_IO_POR] |=> flag_q[RCF_BIT_IO_POR];
    endproperty
    a_io_wr_one: assert property (p_io_wr_one) else $error("io write lost");

    // writing a one to the core flag stores a one
    // the write touches only the stored bit
    property p_core_wr_one;
        @(posedge clk) disable iff (!rstn)
            wr_hit && wdata[RCF_BIT_CORE_POR] |=> flag_q[RCF_BIT_CORE_POR];
    endproperty
    a_core_wr_one: assert property (p_core_wr_one) else $error("core write lost");

    // a lone io one written with no events sets nothing else
    // no reset side effect reaches the other flags
    property p_io_wr_only;
        @(posedge clk) disable iff (!rstn)
            s_clr_req ##0 wdata == (32'h1 << RCF_BIT_IO_POR) |=> flag_q == $past(wdata);
    endproperty
    a_io_wr_only: assert property (p_io_wr_only) else $error("io write spread");

    // a lone core one written with no events sets nothing else
    // no reset side effect reaches the other flags
    property p_core_wr_only;
        @(posedge clk) disable iff (!rstn)
            s_clr_req ##0 wdata == (32'h1 << RCF_BIT_CORE_POR) |=> flag_q == $past(wdata);
    endproperty
    a_core_wr_only: assert property (p_core_wr_only) else $error("core write spread");

    // a write with no events stores exactly the masked data
    // this is how software clears what it has read
    property p_clear;
        @(posedge clk) disable iff (!rstn)
            s_clr_req |=> s_clr_done;
    endproperty
    a_clear: assert property (p_clear) else $error("clear value wrong");

    // a read never shows a one at an unimplemented position
    // those bits read as zero
    property p_unimpl_rd;
        @(posedge clk) disable iff (!rstn)
            rd_hit |=> (rdata & ~RCF_IMPL_MASK) == 32'h0000_0000;
    endproperty
    a_unimpl_rd: assert property (p_unimpl_rd) else $error("unimplemented bit read");

    // a write to another address leaves the flags alone
    // events in that cycle still land
    property p_miss_wr;
        @(posedge clk) disable iff (!rstn)
            wr && !hit |=> flag_q == ($past(flag_q) | $past(set_m));
    endproperty
    a_miss_wr: assert property (p_miss_wr) else $error("stray write stored");

    // a read of another address returns zero
    // only one register is mapped
    property p_miss_rd;
        @(posedge clk) disable iff (!rstn)
            rd && !hit |=> rdata == 32'h0000_0000;
    endproperty
    a_miss_rd: assert property (p_miss_rd) else $error("stray read not zero");

    // timer and power events on the low bits set their flags
    // these are plain sticky flags like the rest
    property p_low_set;
        @(posedge clk) disable iff (!rstn)
            set_m[5:0] != 6'h00 |=> (flag_q[5:0] & $past(set_m[5:0])) == $past(set_m[5:0]);
    endproperty
    a_low_set: assert property (p_low_set) else $error("low flag not set");

    // at the first edge after reset the flags hold the power-on value
    // brown-out, power-on and both backup flags read one
    property p_boot;
        @(posedge clk) disable iff (!rstn)
            boot_q |-> flag_q == RCF_RESET_VAL;
    endproperty
    a_boot: assert property (p_boot) else $error("reset value wrong");

    // the mirror output always equals the stored flags
    // both load from the same next value at the same edge
    property p_mirror;
        @(posedge clk) disable iff (!rstn)
            flags == flag_q;
    endproperty
    a_mirror: assert property (p_mirror) else $error("mirror differs");
endmodule // rcf_reset_cause

// ### tb_top.sv
/* tb_top: self-checking bench for rcf_reset_cause.
   assumes rcf_pkg and rcf_reset_cause are compiled first. */
`timescale 1ns/10ps
module tb_top;
import rcf_pkg::*;
logic clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0; // clock, reset, strobes
logic [3:0] addr = 4'h0; // register address
logic [31:0] wdata = 32'h0, hw_set = 32'h0, rdata, flags, v; // data and events
int n_fail = 0, n_checks = 0; // mismatch and comparison counts
rcf_reset_cause uut (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .hw_set(hw_set), .rdata(rdata), .flags(flags));
// 40 MHz clock
initial forever #12.5 clk = ~clk;
// compare seen against expected
task chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
        n_fail++;
        $display("Error %0t: got %h expected %h", $time, s, e);
    end
endtask
// one-cycle write, with an optional hardware event in the same cycle
task wr_t(input logic [3:0] a, input logic [31:0] d, input logic [31:0] h);
    @(posedge clk);
    wr <= 1'b1; addr <= a; wdata <= d; hw_set <= h;
    @(posedge clk);
    wr <= 1'b0; hw_set <= 32'h0;
endtask
// one-cycle read, data taken in the following cycle
task rd_t(input logic [3:0] a);
    @(posedge clk);
    rd <= 1'b1; addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
endtask
// reset value seen live and through a read
task t_reset();
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    chk(flags, RCF_RESET_VAL);
    chk(rdata, 32'h0);
    rd_t(RCF_ADDR_FLAGS);
    chk(v, RCF_RESET_VAL);
endtask
// reset again in mid-run: every flag returns to its power-on value
task t_rerst();
    wr_t(RCF_ADDR_FLAGS, 32'h0, 32'hffff_ffff);
    @(posedge clk);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    chk(flags, RCF_RESET_VAL);
    rstn <= 1'b1;
    @(posedge clk);
    #1 chk(flags, RCF_RESET_VAL);
    rd_t(RCF_ADDR_FLAGS);
    chk(v, RCF_RESET_VAL);
endtask
// writing ones only stores implemented bits; unmapped place ignored
task t_write();
    wr_t(RCF_ADDR_FLAGS, 32'hffff_ffff, 32'h0);
    rd_t(RCF_ADDR_FLAGS);
    chk(v, RCF_IMPL_MASK);
    wr_t(4'h3, 32'h0, 32'h0);
    rd_t(4'h3);
    chk(v, 32'h0);
    chk(flags, RCF_IMPL_MASK);
    wr_t(RCF_ADDR_FLAGS, 32'h0, 32'h0);
    rd_t(RCF_ADDR_FLAGS);
    chk(v, 32'h0);
endtask
// each event wins over a same-cycle clearing write and then stays
task t_hw();
    for (int i = 0; i < 32; i++) begin
        wr_t(RCF_ADDR_FLAGS, 32'h0, 32'h1 << i);
        rd_t(RCF_ADDR_FLAGS);
        chk(v, RCF_IMPL_MASK & (32'h1 << i));
    end
endtask
// counts and verdict
task stop_test();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
endtask
// main sequence
initial begin
    t_reset();
    t_write();
    t_hw();
    t_rerst();
    stop_test();
end
endmodule // tb_top
